// File: design/dsdpc_dbg_flags.sv
// Purpose: debugger power-up request flags held in the always-on domain
// Assumes: link clock and command pins already synchronised
// Notes:   only the power-on reset or a debugger command changes a flag
`timescale 1ns/1ps
module dsdpc_dbg_flags
	import dsdpc_pkg::*;
(
	// clock and reset
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	input  wire logic           ce_i,
	// synchronised link
	input  wire logic           lclk_s_i,
	input  wire dsdpc_dbg_cmd_t cmd_s_i,
	// flags
	output logic                sys_flag_o,
	output logic                dbg_flag_o,
	output logic                sys_rise_o,
	output logic                dbg_rise_o
);
	logic lclk_prev_ff;
	logic nxt_lclk_prev;
	logic nxt_sys;
	logic nxt_dbg;
	logic nxt_sys_rise;
	logic nxt_dbg_rise;
	logic take;

	// ==========================================================
	// command capture on the link clock rising edge
	always_comb begin
		take          = lclk_s_i & ~lclk_prev_ff;
		nxt_lclk_prev = lclk_s_i;
		nxt_sys       = sys_flag_o;
		nxt_dbg       = dbg_flag_o;
		// set beats clear when both arrive in one command
		if (take) begin
			if (cmd_s_i.set_sys) begin
				nxt_sys = 1'b1;
			end else if (cmd_s_i.clr_sys) begin
				nxt_sys = 1'b0;
			end
			if (cmd_s_i.set_dbg) begin
				nxt_dbg = 1'b1;
			end else if (cmd_s_i.clr_dbg) begin
				nxt_dbg = 1'b0;
			end
		end
		nxt_sys_rise = nxt_sys & ~sys_flag_o;
		nxt_dbg_rise = nxt_dbg & ~dbg_flag_o;
		if (!ce_i) begin
			nxt_lclk_prev = lclk_prev_ff;
			nxt_sys       = sys_flag_o;
			nxt_dbg       = dbg_flag_o;
			nxt_sys_rise  = sys_rise_o;
			nxt_dbg_rise  = dbg_rise_o;
		end
	end

	// no other reset input reaches these flops
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lclk_prev_ff <= 1'b0;
			sys_flag_o   <= 1'b0;
			dbg_flag_o   <= 1'b0;
			sys_rise_o   <= 1'b0;
			dbg_rise_o   <= 1'b0;
		end else begin
			lclk_prev_ff <= nxt_lclk_prev;
			sys_flag_o   <= nxt_sys;
			dbg_flag_o   <= nxt_dbg;
			sys_rise_o   <= nxt_sys_rise;
			dbg_rise_o   <= nxt_dbg_rise;
		end
	end
endmodule

// File: design/dsdpc_pkg.sv
// Purpose: shared constants and types of the deep sleep debug power controller
// Assumes: 100 MHz always-on clock
// Notes:   register offsets are byte addresses on the plain register port
package dsdpc_pkg;

	// ==========================================================
	// register map
	localparam logic [31:0] ADDR_PERI_DIS  = 32'h4000_4038;
	localparam logic [31:0] ADDR_SLP_CTRL  = 32'h4000_4100;
	localparam logic [31:0] ADDR_SLP_STAT  = 32'h4000_4104;
	localparam logic [31:0] RST_PERI_DIS   = 32'h0000_0000;
	localparam logic [31:0] RST_SLP_CTRL   = 32'h0000_0000;
	localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;

	// ==========================================================
	// field positions
	localparam int unsigned BIT_SERIAL1_GATE  = 1;
	localparam int unsigned BIT_RSVD_PRESERVE = 5;
	localparam logic [31:0] PERI_DIS_WMASK    = 32'h0000_0022;
	localparam int unsigned BIT_DS2_SELECT    = 0;
	localparam int unsigned BIT_XTAL32_USED   = 1;
	localparam logic [31:0] SLP_CTRL_WMASK    = 32'h0000_0003;
	localparam int unsigned STAT_SYS_FLAG     = 8;
	localparam int unsigned STAT_DBG_FLAG     = 9;
	localparam int unsigned STAT_LFRC_EN      = 10;
	localparam int unsigned STAT_TIMER_RUN    = 11;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned WAKE_TIME_NS  = 1000;
	localparam int unsigned WAKE_CYCLES   =
		(WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_CNT_W    = 8;

	// ==========================================================
	// types
	typedef struct packed {
		logic set_sys;
		logic clr_sys;
		logic set_dbg;
		logic clr_dbg;
	} dsdpc_dbg_cmd_t;

	typedef enum logic [6:0] {
		ST_RUN   = 7'h01,
		ST_IDLE  = 7'h02,
		ST_PRE   = 7'h04,
		ST_SLP0  = 7'h08,
		ST_SLP1  = 7'h10,
		ST_SLP2  = 7'h20,
		ST_WAKE  = 7'h40
	} dsdpc_state_t;

endpackage

// File: design/dsdpc_sync.sv
// Purpose: two-stage synchroniser, one chain per bit
// Assumes: inputs are asynchronous to CLK
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module dsdpc_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         ce_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_q;

	// ==========================================================
	// per-bit chains
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				nxt_meta[i] = ce_i ? d_i[i] : meta_ff[i];
				nxt_q[i]    = ce_i ? meta_ff[i] : q_o[i];
			end
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					meta_ff[i] <= 1'b0;
					q_o[i]     <= 1'b0;
				end else begin
					meta_ff[i] <= nxt_meta[i];
					q_o[i]     <= nxt_q[i];
				end
			end
		end
	endgenerate
endmodule

// File: design/dsdpc_top.sv
// Purpose: deep sleep state selection, debug power-up handling, peripheral clock gate
// Assumes: RSTN_I is the power-on reset of the always-on domain
// Notes:   debugger commands arrive on pins sampled on the link clock edge
//
// Function
// - default deep sleep keeps RC oscillator running
// - deep sleep 2 switches RC oscillator off
// - no timer wakes in sleep 2 without crystal
// - non-timer wakes still work in sleep 2
// - any wake from sleep 2 restarts oscillator
// - debug flag set allows only emulated sleep
// - emulated sleep keeps core powered, no core reset
// - system flag set defers any deep sleep
// - true sleep only when both flags clear
// - setting either flag wakes from deep sleep
// - debug access stalls until power-up completes
// - flags cleared only by power-on or debugger
// - attaching debugger alone changes no flag
// - clock-disable register, bit 1 gates serial one
// - disabled peripheral ignores register writes
// - emulated sleep resets peripherals only, not the core
// - deep request is wait with deep bit set
`timescale 1ns/1ps
module dsdpc_top
	import dsdpc_pkg::*;
#(
	parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
	// clock, reset, enable
	input  wire logic                     CLK_I,
	input  wire logic                     RSTN_I,
	input  wire logic                     CE_I,
	// register port
	input  wire logic [31:0]              REG_ADDR_I,
	input  wire logic [31:0]              REG_WDATA_I,
	input  wire logic                     REG_WR_I,
	input  wire logic                     REG_RD_I,
	output logic      [31:0]              REG_RDATA_O,
	// processor sleep request
	input  wire logic                     WFI_I,
	input  wire logic                     SLEEPDEEP_I,
	input  wire logic                     IRQ_I,
	// wake sources
	input  wire logic                     GPIO_WAKE_I,
	input  wire logic                     TIMER_WAKE_I,
	// debug access port
	input  wire logic                     DBG_CLK_I,
	input  wire dsdpc_pkg::dsdpc_dbg_cmd_t DBG_CMD_I,
	input  wire logic                     DBG_ACCESS_I,
	output logic                          DBG_STALL_O,
	output logic                          SYS_PWRUP_O,
	output logic                          DBG_PWRUP_O,
	// power and clock controls
	output logic                          CORE_PWR_EN_O,
	output logic                          CORE_RSTN_O,
	output logic                          PERIPH_RSTN_O,
	output logic                          LFRC_EN_O,
	output logic                          TIMER_RUN_O,
	output logic                          SC1_CLK_EN_O,
	output logic                          SC1_WR_BLOCK_O,
	output logic                          CPU_IDLE_O
);
	// ==========================================================
	// synchronisers and debug flags
	logic [6:0]     async_s;
	dsdpc_dbg_cmd_t cmd_s;
	logic           lclk_s;
	logic           access_s;
	logic           gpio_s;
	logic           sys_flag;
	logic           dbg_flag;
	logic           sys_rise;
	logic           dbg_rise;

	dsdpc_sync #(
		.W (7)
	) u_sync (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.ce_i   (CE_I),
		.d_i    ({DBG_CLK_I, DBG_CMD_I, DBG_ACCESS_I, GPIO_WAKE_I}),
		.q_o    (async_s)
	);

	always_comb begin
		lclk_s   = async_s[6];
		cmd_s    = dsdpc_dbg_cmd_t'(async_s[5:2]);
		access_s = async_s[1];
		gpio_s   = async_s[0];
	end

	dsdpc_dbg_flags u_flags (
		.clk_i      (CLK_I),
		.rstn_i     (RSTN_I),
		.ce_i       (CE_I),
		.lclk_s_i   (lclk_s),
		.cmd_s_i    (cmd_s),
		.sys_flag_o (sys_flag),
		.dbg_flag_o (dbg_flag),
		.sys_rise_o (sys_rise),
		.dbg_rise_o (dbg_rise)
	);

	// ==========================================================
	// registers
	logic [31:0] peri_dis_ff;
	logic [31:0] nxt_peri_dis;
	logic [31:0] slp_ctrl_ff;
	logic [31:0] nxt_slp_ctrl;
	logic [31:0] nxt_rdata;
	logic [31:0] status;
	// state is declared here because the status word reads it
	dsdpc_state_t state_ff;
	dsdpc_state_t nxt_state;

	always_comb begin
		nxt_peri_dis = peri_dis_ff;
		nxt_slp_ctrl = slp_ctrl_ff;
		nxt_rdata    = 32'h0000_0000;
		status       = 32'h0000_0000;
		status[6:0]  = state_ff;
		status[STAT_SYS_FLAG]  = sys_flag;
		status[STAT_DBG_FLAG]  = dbg_flag;
		status[STAT_LFRC_EN]   = LFRC_EN_O;
		status[STAT_TIMER_RUN] = TIMER_RUN_O;
		// reserved bit 5 is kept as written; software is expected to preserve it
		if (REG_WR_I) begin
			if (REG_ADDR_I == ADDR_PERI_DIS) begin
				nxt_peri_dis = REG_WDATA_I & PERI_DIS_WMASK;
			end else if (REG_ADDR_I == ADDR_SLP_CTRL) begin
				nxt_slp_ctrl = REG_WDATA_I & SLP_CTRL_WMASK;
			end
		end
		if (REG_RD_I) begin
			if (REG_ADDR_I == ADDR_PERI_DIS) begin
				nxt_rdata = peri_dis_ff;
			end else if (REG_ADDR_I == ADDR_SLP_CTRL) begin
				nxt_rdata = slp_ctrl_ff;
			end else if (REG_ADDR_I == ADDR_SLP_STAT) begin
				nxt_rdata = status;
			end else begin
				nxt_rdata = RD_UNMAPPED;
			end
		end
		if (!CE_I) begin
			nxt_peri_dis = peri_dis_ff;
			nxt_slp_ctrl = slp_ctrl_ff;
			nxt_rdata    = REG_RDATA_O;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			peri_dis_ff <= RST_PERI_DIS;
			slp_ctrl_ff <= RST_SLP_CTRL;
			REG_RDATA_O <= 32'h0000_0000;
		end else begin
			peri_dis_ff <= nxt_peri_dis;
			slp_ctrl_ff <= nxt_slp_ctrl;
			REG_RDATA_O <= nxt_rdata;
		end
	end

	// ==========================================================
	// power state machine
	logic [WAKE_CNT_W-1:0]  wake_cnt_ff;
	logic [WAKE_CNT_W-1:0]  nxt_wake_cnt;
	logic                   gpio_prev_ff;
	logic                   nxt_gpio_prev;
	logic                   gpio_evt;
	logic                   timer_ok;
	logic                   timer_evt;
	logic                   flag_evt;
	logic                   any_wake;
	logic                   nxt_core_pwr;
	logic                   nxt_core_rstn;
	logic                   nxt_periph_rstn;
	logic                   nxt_lfrc;
	logic                   nxt_timer_run;
	logic                   nxt_stall;
	logic                   nxt_idle;

	always_comb begin
		nxt_gpio_prev = gpio_s;
		gpio_evt      = gpio_s ^ gpio_prev_ff;
		// sleep timer and watchdog live on the RC oscillator or the crystal
		timer_ok      = LFRC_EN_O | slp_ctrl_ff[BIT_XTAL32_USED];
		timer_evt     = TIMER_WAKE_I & timer_ok;
		flag_evt      = sys_rise | dbg_rise;
		any_wake      = gpio_evt | timer_evt | flag_evt;
		nxt_state     = state_ff;
		nxt_wake_cnt  = wake_cnt_ff;
		nxt_lfrc      = LFRC_EN_O;
		case (state_ff)
			ST_RUN: begin
				if (WFI_I && SLEEPDEEP_I) begin
					nxt_state = ST_PRE;
				end else if (WFI_I) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (IRQ_I) begin
					nxt_state = ST_RUN;
				end
			end
			ST_PRE: begin
				if (sys_flag) begin
					nxt_state = ST_PRE;
				end else if (dbg_flag) begin
					nxt_state = ST_SLP0;
				end else if (slp_ctrl_ff[BIT_DS2_SELECT]) begin
					nxt_state = ST_SLP2;
					nxt_lfrc  = 1'b0;
				end else begin
					nxt_state = ST_SLP1;
				end
			end
			ST_SLP0: begin
				if (any_wake) begin
					nxt_state = ST_RUN;
				end
			end
			ST_SLP1, ST_SLP2: begin
				if (any_wake) begin
					nxt_state    = ST_WAKE;
					nxt_wake_cnt = WAKE_CNT_W'(WAKE_CNT - 1);
					nxt_lfrc     = 1'b1;
				end
			end
			ST_WAKE: begin
				if (wake_cnt_ff == '0) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_wake_cnt = wake_cnt_ff - 1'b1;
				end
			end
			default: begin
				nxt_state = ST_RUN;
				nxt_lfrc  = 1'b1;
			end
		endcase
		nxt_core_pwr    = (nxt_state != ST_SLP1) && (nxt_state != ST_SLP2);
		nxt_core_rstn   = (nxt_state != ST_SLP1) && (nxt_state != ST_SLP2) &&
		                  (nxt_state != ST_WAKE);
		nxt_periph_rstn = nxt_core_rstn && (nxt_state != ST_SLP0);
		nxt_timer_run   = nxt_lfrc | slp_ctrl_ff[BIT_XTAL32_USED];
		nxt_stall       = access_s && (nxt_state != ST_RUN) &&
		                  (nxt_state != ST_IDLE);
		nxt_idle        = (nxt_state == ST_IDLE);
		if (!CE_I) begin
			nxt_gpio_prev   = gpio_prev_ff;
			nxt_state       = state_ff;
			nxt_wake_cnt    = wake_cnt_ff;
			nxt_lfrc        = LFRC_EN_O;
			nxt_core_pwr    = CORE_PWR_EN_O;
			nxt_core_rstn   = CORE_RSTN_O;
			nxt_periph_rstn = PERIPH_RSTN_O;
			nxt_timer_run   = TIMER_RUN_O;
			nxt_stall       = DBG_STALL_O;
			nxt_idle        = CPU_IDLE_O;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_ff      <= ST_RUN;
			wake_cnt_ff   <= '0;
			gpio_prev_ff  <= 1'b0;
			LFRC_EN_O     <= 1'b1;
			TIMER_RUN_O   <= 1'b1;
			CORE_PWR_EN_O <= 1'b1;
			CORE_RSTN_O   <= 1'b1;
			PERIPH_RSTN_O <= 1'b1;
			DBG_STALL_O   <= 1'b0;
			CPU_IDLE_O    <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			wake_cnt_ff   <= nxt_wake_cnt;
			gpio_prev_ff  <= nxt_gpio_prev;
			LFRC_EN_O     <= nxt_lfrc;
			TIMER_RUN_O   <= nxt_timer_run;
			CORE_PWR_EN_O <= nxt_core_pwr;
			CORE_RSTN_O   <= nxt_core_rstn;
			PERIPH_RSTN_O <= nxt_periph_rstn;
			DBG_STALL_O   <= nxt_stall;
			CPU_IDLE_O    <= nxt_idle;
		end
	end

	// ==========================================================
	// flag acknowledges and serial one clock gate
	logic nxt_sys_ack;
	logic nxt_dbg_ack;
	logic nxt_sc1_en;
	logic nxt_sc1_blk;

	always_comb begin
		nxt_sys_ack = sys_flag;
		nxt_dbg_ack = dbg_flag;
		nxt_sc1_en  = ~nxt_peri_dis[BIT_SERIAL1_GATE];
		// the gated peripheral keeps its last values since its clock is stopped
		nxt_sc1_blk = nxt_peri_dis[BIT_SERIAL1_GATE];
		if (!CE_I) begin
			nxt_sys_ack = SYS_PWRUP_O;
			nxt_dbg_ack = DBG_PWRUP_O;
			nxt_sc1_en  = SC1_CLK_EN_O;
			nxt_sc1_blk = SC1_WR_BLOCK_O;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			SYS_PWRUP_O    <= 1'b0;
			DBG_PWRUP_O    <= 1'b0;
			SC1_CLK_EN_O   <= 1'b1;
			SC1_WR_BLOCK_O <= 1'b0;
		end else begin
			SYS_PWRUP_O    <= nxt_sys_ack;
			DBG_PWRUP_O    <= nxt_dbg_ack;
			SC1_CLK_EN_O   <= nxt_sc1_en;
			SC1_WR_BLOCK_O <= nxt_sc1_blk;
		end
	end
endmodule

// File: tb/dsdpc_chk_props.sv
// Purpose: port checks of the deep sleep debug power controller
// Assumes: single clock domain
// Notes:   bound into every dsdpc_top
`timescale 1ns/1ps
module dsdpc_chk
	import dsdpc_pkg::*;
#(
	parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        CE_I,
	// register port
	input  wire logic [31:0] REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [31:0] REG_RDATA_O,
	// debug and power
	input  wire logic        DBG_CLK_I,
	input  wire logic        DBG_ACCESS_I,
	input  wire logic        DBG_STALL_O,
	input  wire logic        SYS_PWRUP_O,
	input  wire logic        DBG_PWRUP_O,
	input  wire logic        CORE_PWR_EN_O,
	input  wire logic        CORE_RSTN_O,
	input  wire logic        PERIPH_RSTN_O,
	input  wire logic        LFRC_EN_O,
	input  wire logic        TIMER_RUN_O,
	input  wire logic        SC1_CLK_EN_O,
	input  wire logic        SC1_WR_BLOCK_O
);
	// ==========================================================
	// helpers
	logic [3:0] quiet_ff;
	logic [7:0] wake_ff;
	// quiet counts cycles with the link clock idle, saturating at 15
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			quiet_ff <= 4'h0;
			wake_ff  <= 8'h0;
		end else begin
			quiet_ff <= DBG_CLK_I ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
			wake_ff  <= (CORE_PWR_EN_O && !CORE_RSTN_O) ? wake_ff + 8'h1 : 8'h0;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	// flag outputs trail the internal flags by one edge, so look at them as power drops
	true_sleep_a: assert property ($fell(CORE_PWR_EN_O) |->
		!DBG_PWRUP_O && !SYS_PWRUP_O) else $error("power down with flag set");
	off_resets_a: assert property (!CORE_PWR_EN_O |-> !CORE_RSTN_O && !PERIPH_RSTN_O)
		else $error("resets released while unpowered");
	emul_power_a: assert property (CORE_RSTN_O && !PERIPH_RSTN_O |-> CORE_PWR_EN_O)
		else $error("emulated sleep lost core power");
	timer_src_a: assert property (LFRC_EN_O |-> TIMER_RUN_O)
		else $error("timer stopped with oscillator on");
	osc_off_a: assert property (!LFRC_EN_O |-> !CORE_PWR_EN_O)
		else $error("oscillator off while awake");
	osc_restart_a: assert property ($rose(CORE_PWR_EN_O) |-> LFRC_EN_O)
		else $error("wake without oscillator");
	wake_len_a: assert property (int'(wake_ff) <= WAKE_CNT + 1)
		else $error("wake phase too long");
	sc1_gate_a: assert property (REG_WR_I && CE_I && REG_ADDR_I == ADDR_PERI_DIS
		|-> ##2 SC1_CLK_EN_O == !$past(REG_WDATA_I[1], 2)) else $error("gate mismatch");
	wr_block_a: assert property (SC1_WR_BLOCK_O == !SC1_CLK_EN_O)
		else $error("write block disagrees with gate");
	rd_idle_a: assert property (!REG_RD_I && CE_I |=> REG_RDATA_O == 32'h0)
		else $error("read data outside read");
	flag_hold_a: assert property (quiet_ff > 4'h9 |-> $stable({SYS_PWRUP_O, DBG_PWRUP_O}))
		else $error("flag changed without command");
	access_stall_a: assert property ((DBG_ACCESS_I && !CORE_PWR_EN_O) [*5] |-> DBG_STALL_O)
		else $error("access not stalled");
	cover property ($fell(CORE_PWR_EN_O));
	cover property (!LFRC_EN_O);
	cover property ($rose(DBG_STALL_O));
endmodule
bind dsdpc_top dsdpc_chk #(.WAKE_CNT(WAKE_CNT)) u_chk (.*);

// File: tb/dsdpc_dbg_model.sv
// Purpose: behavioural debugger on the debug access port
// Assumes: link clock of 160 ns, idle low between commands
// Notes:   command pins carry garbage outside a frame
`timescale 1ns/1ps
module dsdpc_dbg_model (
	// link pins
	output logic                      dbg_clk_o,
	output dsdpc_pkg::dsdpc_dbg_cmd_t dbg_cmd_o,
	output logic                      dbg_access_o,
	input  wire logic                 dbg_stall_i
);
	logic saw_stall;
	initial begin
		dbg_clk_o = 1'b0;
		dbg_cmd_o = '0;
		dbg_access_o = 1'b0;
		saw_stall = 1'b0;
	end
	// one framed command; flags change only through these
	task automatic send(input dsdpc_pkg::dsdpc_dbg_cmd_t c);
		dbg_cmd_o = c;
		#80ns dbg_clk_o = 1'b1;
		#80ns dbg_clk_o = 1'b0;
		#80ns dbg_cmd_o = ~c;
	endtask
	// waits out the stall, giving up after 400 polls of 10 ns
	task automatic access();
		int n;
		saw_stall = 1'b0;
		dbg_access_o = 1'b1;
		for (n = 0; n < 400 && !(n > 8 && dbg_stall_i === 1'b0); n++) begin
			#10ns;
			if (dbg_stall_i === 1'b1) saw_stall = 1'b1;
		end
		dbg_access_o = 1'b0;
	endtask
endmodule

// File: tb/tb.sv
// Purpose: directed bench of the deep sleep debug power controller
// Assumes: short wake count of 4 cycles
// Notes:   state is observed through the status register
`timescale 1ns/1ps
module tb;
	import dsdpc_pkg::*;
	logic CLK_I, RSTN_I, CE_I, REG_WR_I, REG_RD_I, WFI_I, SLEEPDEEP_I, IRQ_I;
	logic GPIO_WAKE_I, TIMER_WAKE_I, DBG_CLK_I, DBG_ACCESS_I, DBG_STALL_O;
	logic SYS_PWRUP_O, DBG_PWRUP_O, CORE_PWR_EN_O, CORE_RSTN_O, PERIPH_RSTN_O;
	logic LFRC_EN_O, TIMER_RUN_O, SC1_CLK_EN_O, SC1_WR_BLOCK_O, CPU_IDLE_O;
	logic [31:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, v;
	dsdpc_dbg_cmd_t DBG_CMD_I;
	int errors, n_tests;
	dsdpc_top #(.WAKE_CNT(4)) u_dut (.*);
	dsdpc_dbg_model u_dbg (.dbg_clk_o(DBG_CLK_I), .dbg_cmd_o(DBG_CMD_I),
		.dbg_access_o(DBG_ACCESS_I), .dbg_stall_i(DBG_STALL_O));
	// ==========================================================
	// bus and helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		@(posedge CLK_I);
		REG_WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge CLK_I);
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= a;
		@(posedge CLK_I);
		REG_RD_I <= 1'b0;
		#1 d = REG_RDATA_O;
	endtask
	task automatic wait_st(input logic [6:0] s);
		logic [31:0] d;
		int n;
		n = 0;
		do begin
			rd(ADDR_SLP_STAT, d);
			n++;
		end while (d[6:0] !== s && n < 100);
		chk({25'h0, d[6:0]}, {25'h0, s});
	endtask
	task automatic sleep(input logic deep);
		@(posedge CLK_I);
		WFI_I <= 1'b1;
		SLEEPDEEP_I <= deep;
		@(posedge CLK_I);
		WFI_I <= 1'b0;
	endtask
	task automatic pulse(input logic timer);
		@(posedge CLK_I);
		if (timer) TIMER_WAKE_I <= 1'b1;
		else GPIO_WAKE_I <= ~GPIO_WAKE_I;
		@(posedge CLK_I);
		TIMER_WAKE_I <= 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd(ADDR_SLP_STAT, v);
		chk(v, 32'h0000_0c01);
		rd(ADDR_PERI_DIS, v);
		chk(v, RST_PERI_DIS);
		wr(ADDR_PERI_DIS, (v & 32'h20) | 32'h2);
		tick(1);
		chk({30'h0, SC1_CLK_EN_O, SC1_WR_BLOCK_O}, 32'h1);
		rd(ADDR_PERI_DIS, v);
		chk(v, 32'h2);
		wr(ADDR_PERI_DIS, v & 32'h20);
		wr(32'h4000_4200, 32'hffff_ffff);
		rd(32'h4000_4200, v);
		chk(v, RD_UNMAPPED);
		wr(ADDR_PERI_DIS, 32'hffff_ffdd);
		rd(ADDR_PERI_DIS, v);
		chk(v, 32'h0);
		chk({31'h0, SC1_CLK_EN_O}, 32'h1);
		$display("t_regs done");
	endtask
	// a write while the enable is low must leave the clock-disable register and the serial one gate as they were
	task automatic t_freeze();
		@(posedge CLK_I);
		CE_I <= 1'b0;
		wr(ADDR_PERI_DIS, 32'h2);
		@(posedge CLK_I);
		CE_I <= 1'b1;
		rd(ADDR_PERI_DIS, v);
		chk(v, RST_PERI_DIS);
		chk({31'h0, SC1_CLK_EN_O}, 32'h1);
		$display("t_freeze done");
	endtask
	task automatic t_sleep();
		sleep(1'b0);
		tick(2);
		chk({30'h0, CPU_IDLE_O, CORE_PWR_EN_O}, 32'h3);
		IRQ_I <= 1'b1;
		tick(3);
		chk({31'h0, CPU_IDLE_O}, 32'h0);
		IRQ_I <= 1'b0;
		sleep(1'b1);
		wait_st(ST_SLP1);
		chk({30'h0, CORE_PWR_EN_O, LFRC_EN_O}, 32'h1);
		pulse(1'b0);
		wait_st(ST_RUN);
		wr(ADDR_SLP_CTRL, 32'h1);
		sleep(1'b1);
		wait_st(ST_SLP2);
		chk({30'h0, LFRC_EN_O, TIMER_RUN_O}, 32'h0);
		pulse(1'b1);
		wait_st(ST_SLP2);
		pulse(1'b0);
		wait_st(ST_RUN);
		chk({30'h0, LFRC_EN_O, CORE_RSTN_O}, 32'h3);
		wr(ADDR_SLP_CTRL, 32'h3);
		sleep(1'b1);
		wait_st(ST_SLP2);
		chk({31'h0, TIMER_RUN_O}, 32'h1);
		pulse(1'b1);
		wait_st(ST_RUN);
		wr(ADDR_SLP_CTRL, 32'h0);
		$display("t_sleep done");
	endtask
	task automatic t_debug();
		u_dbg.send(4'h2);
		tick(8);
		chk({31'h0, DBG_PWRUP_O}, 32'h1);
		sleep(1'b1);
		wait_st(ST_SLP0);
		chk({29'h0, CORE_PWR_EN_O, CORE_RSTN_O, PERIPH_RSTN_O}, 32'h6);
		pulse(1'b0);
		wait_st(ST_RUN);
		u_dbg.access();
		chk({30'h0, SYS_PWRUP_O, DBG_PWRUP_O}, 32'h1);
		u_dbg.send(4'h9);
		tick(8);
		chk({30'h0, SYS_PWRUP_O, DBG_PWRUP_O}, 32'h2);
		sleep(1'b1);
		tick(20);
		wait_st(ST_PRE);
		u_dbg.send(4'h4);
		wait_st(ST_SLP1);
		fork
			u_dbg.access();
			u_dbg.send(4'h8);
		join
		chk({31'h0, u_dbg.saw_stall}, 32'h1);
		wait_st(ST_RUN);
		chk({30'h0, SYS_PWRUP_O, DBG_PWRUP_O}, 32'h2);
		u_dbg.send(4'h4);
		$display("t_debug done");
	endtask
	// ==========================================================
	// run control
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end
	initial begin
		#200us;
		errors++;
		tally_and_finish();
	end
	initial begin
		{RSTN_I, REG_WR_I, REG_RD_I, WFI_I, SLEEPDEEP_I, IRQ_I} = '0;
		{GPIO_WAKE_I, TIMER_WAKE_I, REG_ADDR_I, REG_WDATA_I} = '0;
		CE_I = 1'b1;
		errors = 0;
		n_tests = 0;
		repeat (12) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		t_regs();
		t_freeze();
		t_sleep();
		t_debug();
		tally_and_finish();
	end
endmodule
